// ---- logic/prs_print_request_scheduler.sv ----
`timescale 1ns/10ps
module prs_print_request_scheduler #(
    parameter int SEC_CYCLES = prs_pkg::SEC_CYCLES,
    parameter int INTERVAL_W = prs_pkg::INTERVAL_W
) (
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    // configuration
    input  wire logic [1:0]            interface_choice_in,
    input  wire logic [INTERVAL_W-1:0] interval_sec_in,
    // display state
    input  wire logic                  measure_screen_in,
    input  wire logic                  stats_screen_in,
    // requests
    input  wire logic                  print_key_in,
    input  wire logic                  external_control_connector_print_n_in,
    input  wire logic                  measure_trigger_input_in,
    input  wire logic                  stats_enable_in,
    input  wire logic                  internal_trigger_in,
    // statistics state
    input  wire logic [prs_pkg::STAT_W-1:0] stats_valid_count_in,
    // status
    output logic                       interval_run_out,
    output logic                       stats_add_out,
    // body text from the value formatter
    output logic                       body_start_out,
    output logic                       body_stats_out,
    output logic [2:0]                 stats_fields_out,
    input  wire logic [7:0]            body_data_in,
    input  wire logic                  body_valid_in,
    input  wire logic                  body_last_in,
    output logic                       body_ready_out,
    // serial transmit byte stream
    output logic [7:0]                 tx_data_out,
    output logic                       tx_valid_out,
    input  wire logic                  tx_ready_in
);

    // ==========================================================
    // request decode
    localparam int DIV_W = $clog2(SEC_CYCLES);

    logic printer_sel;
    logic ext_prev_reg;
    logic ext_fall;
    logic stats_trigger;
    logic trigger_print;
    logic user_req;
    logic stats_req;
    logic stats_add_reg;

    assign printer_sel   = interface_choice_in == prs_pkg::IFACE_PRINTER;
    assign ext_fall      = ext_prev_reg & ~external_control_connector_print_n_in;
    assign stats_trigger = stats_enable_in & internal_trigger_in & measure_trigger_input_in;
    assign trigger_print = stats_trigger & printer_sel & measure_screen_in;
    assign user_req      = (print_key_in | ext_fall) & printer_sel & measure_screen_in;
    assign stats_req     = print_key_in & printer_sel & stats_screen_in & ~measure_screen_in;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ext_prev_reg  <= 1'b1;
            stats_add_reg <= 1'b0;
        end else begin
            ext_prev_reg  <= external_control_connector_print_n_in;
            stats_add_reg <= stats_trigger;
        end
    end

    // ==========================================================
    // interval control
    logic [INTERVAL_W-1:0] interval_reg;
    logic [INTERVAL_W-1:0] interval_next;
    logic [INTERVAL_W-1:0] sec_cnt_reg;
    logic [INTERVAL_W-1:0] sec_cnt_next;
    logic [DIV_W-1:0]      div_reg;
    logic [DIV_W-1:0]      div_next;
    logic                  run_reg;
    logic                  run_next;
    logic                  single_pend_reg;
    logic                  single_pend_next;
    logic                  timed_pend_reg;
    logic                  timed_pend_next;
    logic                  stats_pend_reg;
    logic                  stats_pend_next;
    logic                  start_run;
    logic                  tick;
    logic                  take_single;
    logic                  take_timed;
    logic                  take_stats;

    assign tick = div_reg == DIV_W'(SEC_CYCLES - 1);

    always_comb begin
        interval_next    = interval_reg;
        sec_cnt_next     = sec_cnt_reg;
        div_next         = tick ? '0 : div_reg + 1'b1;
        run_next         = run_reg;
        single_pend_next = single_pend_reg & ~take_single;
        timed_pend_next  = timed_pend_reg & ~take_timed;
        stats_pend_next  = stats_pend_reg & ~take_stats;
        start_run        = 1'b0;
        // out-of-range settings are refused, the last good one stays
        if (interval_sec_in <= INTERVAL_W'(prs_pkg::INTERVAL_MAX_S)) begin
            interval_next = interval_sec_in;
        end
        if (run_reg && tick) begin
            if (sec_cnt_reg + 1'b1 == interval_reg) begin
                sec_cnt_next    = '0;
                timed_pend_next = 1'b1;
            end else begin
                sec_cnt_next = sec_cnt_reg + 1'b1;
            end
        end
        if (trigger_print || (user_req && interval_reg == '0)) begin
            single_pend_next = 1'b1;
        end else if (user_req && !run_reg) begin
            run_next        = 1'b1;
            start_run       = 1'b1;
            sec_cnt_next    = '0;
            div_next        = '0;
            timed_pend_next = 1'b1;
        end else if (user_req) begin
            run_next = 1'b0;
        end
        if (!measure_screen_in || !printer_sel) begin
            run_next = 1'b0;
        end
        if (stats_req) begin
            stats_pend_next = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            interval_reg    <= '0;
            sec_cnt_reg     <= '0;
            div_reg         <= '0;
            run_reg         <= 1'b0;
            single_pend_reg <= 1'b0;
            timed_pend_reg  <= 1'b0;
            stats_pend_reg  <= 1'b0;
        end else begin
            interval_reg    <= interval_next;
            sec_cnt_reg     <= sec_cnt_next;
            div_reg         <= div_next;
            run_reg         <= run_next;
            single_pend_reg <= single_pend_next;
            timed_pend_reg  <= timed_pend_next;
            stats_pend_reg  <= stats_pend_next;
        end
    end

    // ==========================================================
    // elapsed time and record number digits
    localparam int EL_MOD [prs_pkg::TIME_DIGITS] = '{10, 6, 10, 6, 10, 10};

    logic [3:0] el_digit  [prs_pkg::TIME_DIGITS];
    logic [prs_pkg::TIME_DIGITS-1:0] el_inc;
    logic [prs_pkg::TIME_DIGITS-1:0] el_carry;
    logic [3:0] rec_digit [prs_pkg::REC_DIGITS];
    logic [prs_pkg::REC_DIGITS-1:0]  rec_inc;
    logic [prs_pkg::REC_DIGITS-1:0]  rec_carry;
    logic       rec_adv;
    logic       rec_wrap;

    genvar g;
    generate
        for (g = 0; g < prs_pkg::TIME_DIGITS; g++) begin : gen_elapsed
            if (g == 0) begin : gen_first
                assign el_inc[g] = tick & run_reg;
            end else begin : gen_chain
                assign el_inc[g] = el_carry[g-1];
            end
            // the hour tens digit rolls over on its own, so 100 h reads 00:00:00
            prs_bcd_digit #(
                .MODULUS   (EL_MOD[g]),
                .RESET_VAL (4'h0)
            ) u_el (
                .clk_in      (clk_in),
                .rst_in      (rst_in),
                .load_in     (start_run),
                .load_val_in (4'h0),
                .inc_in      (el_inc[g] & ~start_run),
                .digit_out   (el_digit[g]),
                .carry_out   (el_carry[g])
            );
        end
        for (g = 0; g < prs_pkg::REC_DIGITS; g++) begin : gen_record
            if (g == 0) begin : gen_first
                assign rec_inc[g] = rec_adv;
            end else begin : gen_chain
                assign rec_inc[g] = rec_carry[g-1];
            end
            prs_bcd_digit #(
                .MODULUS   (10),
                .RESET_VAL ((g == 0) ? prs_pkg::REC_FIRST_UNIT : 4'h0)
            ) u_rec (
                .clk_in      (clk_in),
                .rst_in      (rst_in),
                .load_in     (rec_adv & rec_wrap),
                .load_val_in ((g == 0) ? prs_pkg::REC_FIRST_UNIT : 4'h0),
                .inc_in      (rec_inc[g] & ~rec_wrap),
                .digit_out   (rec_digit[g]),
                .carry_out   (rec_carry[g])
            );
        end
    endgenerate

    assign rec_wrap = rec_digit[4] == prs_pkg::REC_TOP_DIGIT && rec_digit[3] == 4'h0
                      && rec_digit[2] == 4'h0 && rec_digit[1] == 4'h0
                      && rec_digit[0] == 4'h0;

    // ==========================================================
    // line formatter
    prs_pkg::prs_line_state_type state_reg;
    prs_pkg::prs_line_state_type state_next;

    logic [3:0]  idx_reg;
    logic [3:0]  idx_next;
    logic        job_stats_reg;
    logic        job_stats_next;
    logic        job_timed_reg;
    logic        job_timed_next;
    logic [23:0] snap_reg;
    logic [23:0] snap_next;
    logic [2:0]  fields_reg;
    logic [2:0]  fields_next;
    logic [7:0]  tx_data_reg;
    logic [7:0]  tx_data_next;
    logic        tx_valid_reg;
    logic        tx_valid_next;
    logic        body_start_reg;
    logic        body_start_next;
    logic        tx_free;
    logic [3:0]  time_digit;
    logic [7:0]  time_char;

    assign tx_free        = ~tx_valid_reg | tx_ready_in;
    assign body_ready_out = (state_reg == prs_pkg::ST_BODY) & tx_free;

    always_comb begin
        unique case (idx_reg)
            4'h0:    time_digit = snap_reg[23:20];
            4'h1:    time_digit = snap_reg[19:16];
            4'h3:    time_digit = snap_reg[15:12];
            4'h4:    time_digit = snap_reg[11:8];
            4'h6:    time_digit = snap_reg[7:4];
            default: time_digit = snap_reg[3:0];
        endcase
        if (idx_reg == 4'h2 || idx_reg == 4'h5) begin
            time_char = prs_pkg::CHAR_COLON;
        end else if (idx_reg == 4'(prs_pkg::TIME_CHARS - 1)) begin
            time_char = prs_pkg::CHAR_SPACE;
        end else begin
            time_char = prs_pkg::CHAR_ZERO | {4'h0, time_digit};
        end
    end

    always_comb begin
        state_next      = state_reg;
        idx_next        = idx_reg;
        job_stats_next  = job_stats_reg;
        job_timed_next  = job_timed_reg;
        snap_next       = snap_reg;
        fields_next     = fields_reg;
        tx_data_next    = tx_data_reg;
        tx_valid_next   = tx_valid_reg & ~tx_ready_in;
        body_start_next = 1'b0;
        take_single     = 1'b0;
        take_timed      = 1'b0;
        take_stats      = 1'b0;
        rec_adv         = 1'b0;
        unique case (state_reg)
            prs_pkg::ST_IDLE: begin
                idx_next = '0;
                // a new job starts only here, after the previous line ended
                if (stats_pend_reg) begin
                    take_stats      = 1'b1;
                    job_stats_next  = 1'b1;
                    job_timed_next  = 1'b0;
                    fields_next     = '0;
                    fields_next[prs_pkg::STAT_COUNT_BIT]   = 1'b1;
                    fields_next[prs_pkg::STAT_SUMMARY_BIT] = stats_valid_count_in != '0;
                    fields_next[prs_pkg::STAT_SPREAD_BIT]  = stats_valid_count_in > 16'h0001;
                    body_start_next = 1'b1;
                    state_next      = prs_pkg::ST_BODY;
                end else if (timed_pend_reg || single_pend_reg) begin
                    take_timed     = timed_pend_reg;
                    take_single    = ~timed_pend_reg;
                    job_stats_next = 1'b0;
                    job_timed_next = timed_pend_reg;
                    fields_next    = '0;
                    snap_next      = {el_digit[5], el_digit[4], el_digit[3],
                                      el_digit[2], el_digit[1], el_digit[0]};
                    state_next     = prs_pkg::ST_NUMBER;
                end
            end
            prs_pkg::ST_NUMBER: begin
                if (tx_free) begin
                    tx_valid_next = 1'b1;
                    tx_data_next  = prs_pkg::CHAR_ZERO
                                    | {4'h0, rec_digit[3'(4 - idx_reg[2:0])]};
                    idx_next      = idx_reg + 4'h1;
                    if (idx_reg == 4'(prs_pkg::REC_DIGITS - 1)) begin
                        state_next = prs_pkg::ST_SPACE;
                    end
                end
            end
            prs_pkg::ST_SPACE: begin
                if (tx_free) begin
                    tx_valid_next = 1'b1;
                    tx_data_next  = prs_pkg::CHAR_SPACE;
                    idx_next      = '0;
                    if (job_timed_reg) begin
                        state_next = prs_pkg::ST_TIME;
                    end else begin
                        body_start_next = 1'b1;
                        state_next      = prs_pkg::ST_BODY;
                    end
                end
            end
            prs_pkg::ST_TIME: begin
                if (tx_free) begin
                    tx_valid_next = 1'b1;
                    tx_data_next  = time_char;
                    idx_next      = idx_reg + 4'h1;
                    if (idx_reg == 4'(prs_pkg::TIME_CHARS - 1)) begin
                        body_start_next = 1'b1;
                        state_next      = prs_pkg::ST_BODY;
                    end
                end
            end
            prs_pkg::ST_BODY: begin
                if (tx_free && body_valid_in) begin
                    tx_valid_next = 1'b1;
                    tx_data_next  = body_data_in;
                    if (body_last_in) begin
                        state_next = prs_pkg::ST_CR;
                    end
                end
            end
            prs_pkg::ST_CR: begin
                if (tx_free) begin
                    tx_valid_next = 1'b1;
                    tx_data_next  = prs_pkg::CHAR_CR;
                    state_next    = prs_pkg::ST_LF;
                end
            end
            prs_pkg::ST_LF: begin
                if (tx_free) begin
                    tx_valid_next = 1'b1;
                    tx_data_next  = prs_pkg::CHAR_LF;
                    rec_adv       = ~job_stats_reg;
                    state_next    = prs_pkg::ST_IDLE;
                end
            end
            default: state_next = prs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg      <= prs_pkg::ST_IDLE;
            idx_reg        <= '0;
            job_stats_reg  <= 1'b0;
            job_timed_reg  <= 1'b0;
            snap_reg       <= '0;
            fields_reg     <= '0;
            tx_data_reg    <= '0;
            tx_valid_reg   <= 1'b0;
            body_start_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            idx_reg        <= idx_next;
            job_stats_reg  <= job_stats_next;
            job_timed_reg  <= job_timed_next;
            snap_reg       <= snap_next;
            fields_reg     <= fields_next;
            tx_data_reg    <= tx_data_next;
            tx_valid_reg   <= tx_valid_next;
            body_start_reg <= body_start_next;
        end
    end

    // ==========================================================
    // outputs
    assign interval_run_out = run_reg;
    assign stats_add_out    = stats_add_reg;
    assign body_start_out   = body_start_reg;
    assign body_stats_out   = job_stats_reg;
    assign stats_fields_out = fields_reg;
    assign tx_data_out      = tx_data_reg;
    assign tx_valid_out     = tx_valid_reg;

endmodule : prs_print_request_scheduler

// ---- logic/prs_pkg.sv ----
package prs_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS    = 5;
    localparam int SECOND_NS        = 1000000000;
    localparam int SEC_CYCLES       = SECOND_NS / CLK_PERIOD_NS;

    // ==========================================================
    // interval setting, whole seconds
    localparam int INTERVAL_MAX_S   = 3600;
    localparam int INTERVAL_W       = 12;

    // ==========================================================
    // interface selection codes
    localparam logic [1:0] IFACE_SERIAL_CONTROL_CHOICE = 2'h0;
    localparam logic [1:0] IFACE_GPIB                  = 2'h1;
    localparam logic [1:0] IFACE_PRINTER               = 2'h2;

    // ==========================================================
    // counters: record number and elapsed time, in decimal digits
    localparam int REC_DIGITS       = 5;
    localparam int TIME_DIGITS      = 6;
    localparam int TIME_CHARS       = 9;
    localparam logic [3:0] REC_TOP_DIGIT  = 4'h3;
    localparam logic [3:0] REC_FIRST_UNIT = 4'h1;

    // ==========================================================
    // ascii
    localparam logic [7:0] CHAR_ZERO  = 8'h30;
    localparam logic [7:0] CHAR_COLON = 8'h3A;
    localparam logic [7:0] CHAR_SPACE = 8'h20;
    localparam logic [7:0] CHAR_CR    = 8'h0D;
    localparam logic [7:0] CHAR_LF    = 8'h0A;

    // ==========================================================
    // statistics field mask bits
    localparam int STAT_COUNT_BIT   = 0;
    localparam int STAT_SUMMARY_BIT = 1;
    localparam int STAT_SPREAD_BIT  = 2;
    localparam int STAT_W           = 16;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_NUMBER,
        ST_SPACE,
        ST_TIME,
        ST_BODY,
        ST_CR,
        ST_LF
    } prs_line_state_type;

endpackage : prs_pkg

// ---- logic/prs_bcd_digit.sv ----
`timescale 1ns/10ps
module prs_bcd_digit #(
    parameter int          MODULUS   = 10,
    parameter logic [3:0]  RESET_VAL = 4'h0
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // control
    input  wire logic       load_in,
    input  wire logic [3:0] load_val_in,
    input  wire logic       inc_in,
    // state
    output logic      [3:0] digit_out,
    output logic            carry_out
);

    // ==========================================================
    // digit
    localparam logic [3:0] TOP = 4'(MODULUS - 1);

    logic [3:0] digit_reg;
    logic [3:0] digit_next;

    always_comb begin
        digit_next = digit_reg;
        if (load_in) begin
            digit_next = load_val_in;
        end else if (inc_in) begin
            digit_next = (digit_reg == TOP) ? 4'h0 : digit_reg + 4'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            digit_reg <= RESET_VAL;
        end else begin
            digit_reg <= digit_next;
        end
    end

    assign digit_out = digit_reg;
    assign carry_out = inc_in & (digit_reg == TOP);

endmodule : prs_bcd_digit

// ---- test/prs_assertions.sv ----
`timescale 1ns/10ps
module prs_checker #(
    parameter int INTERVAL_W = prs_pkg::INTERVAL_W
) (
    // clock, reset and inputs
    input wire logic                  clk_in,
    input wire logic                  rst_in,
    input wire logic [1:0]            interface_choice_in,
    input wire logic [INTERVAL_W-1:0] interval_sec_in,
    input wire logic                  measure_screen_in,
    input wire logic                  stats_screen_in,
    input wire logic                  print_key_in,
    input wire logic                  measure_trigger_input_in,
    input wire logic                  stats_enable_in,
    input wire logic                  internal_trigger_in,
    input wire logic [15:0]           stats_valid_count_in,
    input wire logic                  tx_ready_in,
    // outputs
    input wire logic                  interval_run_out,
    input wire logic                  stats_add_out,
    input wire logic                  body_start_out,
    input wire logic                  body_stats_out,
    input wire logic [2:0]            stats_fields_out,
    input wire logic [7:0]            tx_data_out,
    input wire logic                  tx_valid_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic pr;
    logic key_ok;
    assign pr = interface_choice_in == prs_pkg::IFACE_PRINTER;
    assign key_ok = print_key_in && pr && measure_screen_in && !stats_screen_in;
    // ==========================================================
    // run control
    iface_stop_a: assert property (interval_run_out && !pr |=> !interval_run_out)
        else $error("interval run kept off printer");
    zero_no_run_a: assert property (interval_sec_in == '0 && $past(interval_sec_in) == '0
        && !interval_run_out |=> !interval_run_out) else $error("run with zero interval");
    // the setting is registered, so a request in the cycle it changes sees the old one
    run_start_a: assert property (key_ok && interval_sec_in != '0
        && interval_sec_in <= 3600 && $stable(interval_sec_in) && !interval_run_out
        |-> ##[1:2] interval_run_out) else $error("run not started");
    run_stop_a: assert property (key_ok && interval_run_out |-> ##[1:2] !interval_run_out)
        else $error("run not stopped");
    screen_stop_a: assert property (interval_run_out && !measure_screen_in |=> !interval_run_out)
        else $error("run kept off screen");
    // ==========================================================
    // statistics and serial line
    stats_add_a: assert property (measure_trigger_input_in && stats_enable_in
        && internal_trigger_in |=> stats_add_out) else $error("no stats add");
    stats_none_a: assert property (body_start_out && body_stats_out
        && stats_valid_count_in == 0 |-> stats_fields_out == 3'h1)
        else $error("fields with no sample");
    stats_one_a: assert property (body_start_out && body_stats_out
        && stats_valid_count_in == 1 |-> stats_fields_out == 3'h3)
        else $error("fields with one sample");
    tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out
        && $stable(tx_data_out)) else $error("tx byte dropped");
    line_end_a: assert property (tx_valid_out && tx_ready_in && tx_data_out == prs_pkg::CHAR_CR
        |-> ##[1:3] (tx_valid_out && tx_data_out == prs_pkg::CHAR_LF))
        else $error("no line feed after return");
endmodule : prs_checker
bind prs_print_request_scheduler prs_checker #(.INTERVAL_W(INTERVAL_W)) chk (.*);

// ---- test/prs_printer_model.sv ----
`timescale 1ns/10ps
module prs_printer_model (
    // clock, reset and speed select
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire logic          slow_in,
    // serial byte stream
    input  wire logic [7:0]    tx_data_in,
    input  wire logic          tx_valid_in,
    output logic               tx_ready_out,
    // last complete line, right aligned
    output logic [8*20-1:0]    line_out,
    output int                 n_lines
);
    logic [8*20-1:0] acc;
    logic [1:0]      ph;
    // a slow printer is busy three cycles in four
    assign tx_ready_out = !(slow_in && ph != 2'h0);
    always @(posedge clk_in) begin
        ph <= ph + 2'h1;
        if (rst_in) begin
            {acc, line_out, ph} <= '0;
            n_lines <= 0;
        end else if (tx_valid_in && tx_ready_out) begin
            acc <= (tx_data_in == prs_pkg::CHAR_LF) ? '0 : {acc[8*19-1:0], tx_data_in};
            if (tx_data_in == prs_pkg::CHAR_LF) begin
                line_out <= {acc[8*19-1:0], tx_data_in};
                n_lines  <= n_lines + 1;
            end
        end
    end
endmodule : prs_printer_model

// ---- test/prs_print_request_scheduler_tb.sv ----
`timescale 1ns/10ps
module prs_print_request_scheduler_tb;
    localparam int SEC = 20;
    logic            clk_in, rst_in, key, ext_n, measure_trigger_input, st_en, int_measure_trigger_input, ms, ss, slow;
    logic            run, add, bstart, bstats, bvalid, bready, txv, txr;
    logic [1:0]      iface;
    logic [11:0]     ivl;
    logic [15:0]     nvalid;
    logic [2:0]      fields;
    logic [7:0]      txd;
    logic [8*20-1:0] line;
    int              nl;
    int              n_mismatch = 0;
    int              checks_done = 0;
    int              rec = 1;

    prs_print_request_scheduler #(.SEC_CYCLES(SEC), .INTERVAL_W(12)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .interface_choice_in(iface), .interval_sec_in(ivl),
        .measure_screen_in(ms), .stats_screen_in(ss), .print_key_in(key),
        .external_control_connector_print_n_in(ext_n), .measure_trigger_input_in(measure_trigger_input),
        .stats_enable_in(st_en), .internal_trigger_in(int_measure_trigger_input), .stats_valid_count_in(nvalid),
        .interval_run_out(run), .stats_add_out(add), .body_start_out(bstart),
        .body_stats_out(bstats), .stats_fields_out(fields), .body_data_in(8'h56),
        .body_valid_in(bvalid), .body_last_in(1'b1), .body_ready_out(bready),
        .tx_data_out(txd), .tx_valid_out(txv), .tx_ready_in(txr));
    prs_printer_model printer (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow),
        .tx_data_in(txd), .tx_valid_in(txv), .tx_ready_out(txr), .line_out(line), .n_lines(nl));

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // one-byte body source standing in for the value formatter
    always @(posedge clk_in)
        if (rst_in || (bvalid && bready)) bvalid <= #1 1'b0;
        else if (bstart) bvalid <= #1 1'b1;

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic check(input logic [8*20-1:0] got, input logic [8*20-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step
    task automatic press;
        key = 1'b1;
        step(1);
        key = 1'b0;
    endtask : press
    function automatic logic [8*20-1:0] pk(input string s);
        pk = '0;
        foreach (s[i]) pk = (pk << 8) | 160'(s[i]);
    endfunction : pk
    // bounded wait for the next complete line, then compare it
    task automatic expect_line(input string s);
        int want;
        int k;
        want = nl + 1;
        k = 0;
        while (nl < want && k < 400) begin
            step(1);
            k++;
        end
        if (nl < want) begin
            n_mismatch++;
            $display("unexpected at %0t: lines %h exp %h", $time, nl, want);
            summarize();
        end
        check(line, pk(s));
    endtask : expect_line

    initial begin
        {key, measure_trigger_input, st_en, int_measure_trigger_input, ss, slow} = '0;
        {ext_n, ms} = 2'h3;
        iface = prs_pkg::IFACE_PRINTER;
        ivl = 12'h0000;
        nvalid = 16'h0000;
        rst_in = 1'b1;
        step(2);
        rst_in = 1'b0;
        press();
        step(1);
        check(txv, 0);
        step(1);
        check(txv, 1);
        expect_line($sformatf("%05d V\015\n", rec++));
        slow = 1'b1;
        ext_n = 1'b0;
        step(3);
        ext_n = 1'b1;
        expect_line($sformatf("%05d V\015\n", rec++));
        slow = 1'b0;
        $display("test single done");
        iface = prs_pkg::IFACE_GPIB;
        press();
        step(1);
        iface = prs_pkg::IFACE_SERIAL_CONTROL_CHOICE;
        press();
        step(1);
        iface = prs_pkg::IFACE_PRINTER;
        ms = 1'b0;
        press();
        step(40);
        check(nl, 2);
        $display("test refuse done");
        ss = 1'b1;
        for (int v = 0; v < 3; v++) begin
            nvalid = 16'(v);
            press();
            step(1);
            check(bstart, 1);
            check(bstats, 1);
            check(fields, (v == 0) ? 3'h1 : (v == 1) ? 3'h3 : 3'h7);
            expect_line("V\015\n");
        end
        {ms, ss} = 2'h2;
        $display("test stats done");
        {st_en, int_measure_trigger_input, measure_trigger_input} = 3'h7;
        step(1);
        measure_trigger_input = 1'b0;
        check(add, 1);
        expect_line($sformatf("%05d V\015\n", rec++));
        st_en = 1'b0;
        $display("test trigger done");
        ivl = 12'h0002;
        // the setting is registered, so let it settle before the request
        step(1);
        press();
        step(1);
        check(run, 1);
        expect_line($sformatf("%05d 00:00:00 V\015\n", rec++));
        expect_line($sformatf("%05d 00:00:02 V\015\n", rec++));
        press();
        step(2);
        check(run, 0);
        press();
        expect_line($sformatf("%05d 00:00:00 V\015\n", rec++));
        ms = 1'b0;
        step(2);
        check(run, 0);
        ms = 1'b1;
        press();
        step(2);
        iface = prs_pkg::IFACE_GPIB;
        step(2);
        check(run, 0);
        $display("test interval done");
        summarize();
    end
endmodule : prs_print_request_scheduler_tb
